// ---- pkg/jtd_pkg.sv ----
// constants and types for the jtag tap and on-chip debug block
// Behaviour
// - from idle, tms 1,0,0 reaches shift-dr
// - shift-dr takes one tdi bit per rising tck edge
// - tdo shifts out the captured parallel values
// - tms 1,1,0 after shifting returns to idle
// - latched outputs load in update-dr, except the reset bit, which loads in shift-dr
// - exit, pause, exit2 states do nothing
// - dr scan may follow ir load directly
// - five tms-high clocks reach test-logic-reset
// - debug ops feed instructions, results via channel
// - flow, single-step and four break points
// - four break points in five mixes
// - tap needs jtag fuse and disable bit clear
// - debug needs fuse and no lock bits
// - opcodes 0x8 to 0xb are debug paths
// - cpu channel write stores byte, sets dirty
// - channel read gives dirty and seven bits
// - shared address: channel only when enabled
// - lock bits block debug fuse until erase
// - fuse programming through the ahb fuse register, not the tap pins
// - boundary chain drives and observes pins
// - transitions use tms at rising tck
// - all shift registers are lsb first
// - power-on reset starts in test-logic-reset
// - instruction register is four bits wide
package jtd_pkg;
    // ****************************************
    // tap
    // ****************************************
    typedef enum logic [3:0] {
        TAP_TLR    = 4'h0,
        TAP_RTI    = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR  = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PA_DR  = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SH_IR  = 4'hb,
        TAP_EX1_IR = 4'hc,
        TAP_PA_IR  = 4'hd,
        TAP_EX2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } jtd_tap_e;
    localparam int IR_W = 4;
    localparam int BS_W = 8;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] OP_EXTEST  = 4'h0;
    localparam logic [IR_W-1:0] OP_IDCODE  = 4'h1;
    localparam logic [IR_W-1:0] OP_SAMPLE  = 4'h2;
    localparam logic [IR_W-1:0] OP_DBG0    = 4'h8;
    localparam logic [IR_W-1:0] OP_DBG1    = 4'h9;
    localparam logic [IR_W-1:0] OP_DBG2    = 4'ha;
    localparam logic [IR_W-1:0] OP_DBG3    = 4'hb;
    localparam logic [IR_W-1:0] OP_RESET   = 4'hc;
    localparam logic [IR_W-1:0] OP_BYPASS  = 4'hf;
    // id fields: values are arbitrary
    localparam logic [3:0]  ID_VER  = 4'h0;
    localparam logic [15:0] ID_PART = 16'h1234;
    localparam logic [10:0] ID_MFR  = 11'h2aa;
    localparam logic [5:0] LEN_ONE   = 6'd1;
    localparam logic [5:0] LEN_BYTE  = 6'd8;
    localparam logic [5:0] LEN_INSTR = 6'd16;
    localparam logic [5:0] LEN_WORD  = 6'd32;
    // debug control fields (op 0xa)
    localparam int CTL_RESUME = 0;
    localparam int CTL_CHEN   = 1;
    localparam int CTL_STEP   = 2;
    localparam int CTL_FLOW   = 3;
    // fuse input order
    localparam int FZ_JTAG = 0;
    localparam int FZ_DBG  = 1;
    localparam int FZ_LB1  = 2;
    localparam int FZ_LB2  = 3;
    // ****************************************
    // break unit
    // ****************************************
    localparam logic [2:0] BP_4P   = 3'h0;
    localparam logic [2:0] BP_3P1D = 3'h1;
    localparam logic [2:0] BP_2P2D = 3'h2;
    localparam logic [2:0] BP_2PPR = 3'h3;
    localparam logic [2:0] BP_2PDR = 3'h4;
    // ****************************************
    // ahb register map
    // ****************************************
    localparam logic [7:0] OFF_MCU    = 8'h00;
    localparam logic [7:0] OFF_CHAN   = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_BPCFG  = 8'h0c;
    localparam logic [7:0] OFF_BP0    = 8'h10;
    localparam logic [7:0] OFF_FUSE   = 8'h20;
    localparam int JTD_BIT   = 7;
    localparam int DIRTY_BIT = 7;
    localparam int FUSE_ERASE = 0;
    localparam int FUSE_PROG  = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ---- core/jtd_tap.sv ----
// jtag tap, debug channel, break unit and ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module jtd_tap
    import jtd_pkg::*;
(
    input  wire logic            hclk,          // system clock
    input  wire logic            hresetn,       // async reset, low
    input  wire logic            hsel,          // slave select
    input  wire logic [31:0]     haddr,         // address
    input  wire logic [1:0]      htrans,        // transfer type
    input  wire logic            hwrite,        // write
    input  wire logic [2:0]      hsize,         // size
    input  wire logic [31:0]     hwdata,        // write data
    input  wire logic            hready,        // bus ready
    output logic                 hreadyout,     // slave ready
    output logic [31:0]          hrdata,        // read data
    output logic                 hresp,         // always okay
    input  wire logic            tck,           // test clock pin
    input  wire logic            tms,           // mode select pin
    input  wire logic            tdi,           // test data in
    output logic                 tdo,           // test data out
    output logic                 tdo_oe,        // tdo drive enable
    input  wire logic            test_port_enable_fuse, // fuse
    input  wire logic            debug_enable_fuse,     // fuse
    input  wire logic            lock_bit_one,  // lock bit
    input  wire logic            lock_bit_two,  // lock bit
    input  wire logic            pc_vld,        // instr fetched
    input  wire logic [15:0]     pc,            // fetch address
    input  wire logic            dacc_vld,      // data access
    input  wire logic [15:0]     daddr,         // data address
    input  wire logic            flow_chg,      // flow change
    output logic                 cpu_halt,      // cpu halted
    output logic [15:0]          instr,         // injected instr
    output logic                 instr_vld,     // instr strobe
    output logic                 sys_rst_req,   // system reset
    output logic                 fuse_prog,     // program debug fuse
    input  wire logic [BS_W-1:0] bs_pin_in,     // pin levels
    output logic [BS_W-1:0]      bs_pin_out,    // pin drive data
    output logic                 bs_pin_drive   // chain owns pins
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]       tck_p;
        logic [1:0]       tms_p;
        logic [1:0]       tdi_p;
        logic [3:0]       fz1;
        logic [3:0]       fz2;
        logic [BS_W-1:0]  pin1;
        logic [BS_W-1:0]  pin2;
        jtd_tap_e         state;
        logic [IR_W-1:0]  ir_sh;
        logic [IR_W-1:0]  ir;
        logic [31:0]      dr_sh;
        logic             tdo;
        logic             tdo_oe;
        logic             rst_bit;
        logic [BS_W-1:0]  bs_lat;
        logic             bs_drv;
        logic             jtd;
        logic [7:0]       chan;
        logic             dirty;
        logic             chan_en;
        logic [7:0]       std_io;
        logic             step_en;
        logic             flow_en;
        logic [2:0]       bp_mode;
        logic [3:0]       bp_en;
        logic [3:0][15:0] bp;
        logic             halted;
        logic [15:0]      instr;
        logic             ivld;
        logic             erased;
        logic             fprog;
        logic             ap_vld;
        logic             ap_wr;
        logic             ap_ok;
        logic [7:0]       ap_addr;
        logic             hrdy;
        logic [31:0]      hrdata;
    } jtd_st_s;

    jtd_st_s st_r;
    jtd_st_s st_nxt;

    // ****************************************
    // functions
    // ****************************************
    function automatic jtd_tap_e tap_next(input jtd_tap_e s,
                                          input logic t);
        case (s)
            TAP_TLR:    tap_next = t ? TAP_TLR    : TAP_RTI;
            TAP_RTI:    tap_next = t ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = t ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = t ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = t ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = t ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = t ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = t ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = t ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = t ? TAP_TLR    : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = t ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = t ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = t ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = t ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = t ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = t ? TAP_SEL_DR : TAP_RTI;
            default:    tap_next = TAP_TLR;
        endcase
    endfunction

    function automatic logic [5:0] dr_len(input logic [IR_W-1:0] o);
        case (o)
            OP_EXTEST, OP_SAMPLE:       dr_len = LEN_BYTE;
            OP_IDCODE:                  dr_len = LEN_WORD;
            OP_DBG0, OP_DBG2, OP_DBG3:  dr_len = LEN_BYTE;
            OP_DBG1:                    dr_len = LEN_INSTR;
            default:                    dr_len = LEN_ONE;
        endcase
    endfunction

    function automatic logic [7:0] bp_off(input int i);
        bp_off = 8'(OFF_BP0 + 4 * i);
    endfunction

    function automatic logic bp_match(input logic [2:0]       m,
                                      input logic [3:0]       en,
                                      input logic [3:0][15:0] a,
                                      input logic             pv,
                                      input logic [15:0]      p,
                                      input logic             dv,
                                      input logic [15:0]      d);
        logic [3:0] ph;
        logic [3:0] dh;
        logic       pr;
        logic       dr;
        ph = '0;
        dh = '0;
        for (int i = 0; i < 4; i++) begin
            ph[i] = pv & en[i] & (p == a[i]);
            dh[i] = dv & en[i] & (d == a[i]);
        end
        // slot 3 acts as a don't-care mask over slot 2
        pr = pv & en[2] & (((p ^ a[2]) & ~a[3]) == 16'h0000);
        dr = dv & en[2] & (((d ^ a[2]) & ~a[3]) == 16'h0000);
        case (m)
            BP_4P:   bp_match = |ph;
            BP_3P1D: bp_match = |ph[2:0] | dh[3];
            BP_2P2D: bp_match = |ph[1:0] | |dh[3:2];
            BP_2PPR: bp_match = |ph[1:0] | pr;
            BP_2PDR: bp_match = |ph[1:0] | dr;
            default: bp_match = |ph[1:0];
        endcase
    endfunction

    // ****************************************
    // next state
    // ****************************************
    logic            rise;
    logic            fall;
    logic            tap_en;
    logic            dbg_en;
    logic            chan_acc;
    logic            locked;
    logic [IR_W-1:0] op;
    logic [31:0]     upd;
    logic [31:0]     rd;
    logic            hit;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ivld = 1'b0;
        st_nxt.fprog = 1'b0;
        // pins and fuses cross in through two flops
        st_nxt.tck_p = {st_r.tck_p[1:0], tck};
        st_nxt.tms_p = {st_r.tms_p[0], tms};
        st_nxt.tdi_p = {st_r.tdi_p[0], tdi};
        st_nxt.fz1 = {lock_bit_two, lock_bit_one,
                      debug_enable_fuse, test_port_enable_fuse};
        st_nxt.fz2 = st_r.fz1;
        st_nxt.pin1 = bs_pin_in;
        st_nxt.pin2 = st_r.pin1;
        rise = st_r.tck_p[1] & ~st_r.tck_p[2];
        fall = ~st_r.tck_p[1] & st_r.tck_p[2];
        tap_en = st_r.fz2[FZ_JTAG] & ~st_r.jtd;
        locked = st_r.fz2[FZ_LB1] | st_r.fz2[FZ_LB2];
        dbg_en = st_r.fz2[FZ_DBG] & ~locked;
        chan_acc = st_r.fz2[FZ_DBG] & st_r.chan_en;
        op = st_r.ir;
        // private paths fall back to bypass when debug is off
        if (op[3:2] == OP_DBG0[3:2] && !dbg_en) begin
            op = OP_BYPASS;
        end
        upd = st_r.dr_sh >> (LEN_WORD - dr_len(op));
        rd = 32'h0;
        hit = 1'b0;

        // ****************************************
        // tap, sampled at the edges of the synced tck
        // ****************************************
        if (!tap_en) begin
            st_nxt.state = TAP_TLR;
            st_nxt.ir = OP_IDCODE;
            st_nxt.tdo_oe = 1'b0;
        end else if (rise) begin
            case (st_r.state)
                TAP_TLR: begin
                    st_nxt.ir = OP_IDCODE;
                end
                TAP_CAP_DR: begin
                    case (op)
                        OP_EXTEST, OP_SAMPLE: begin
                            st_nxt.dr_sh = 32'(st_r.pin2);
                        end
                        OP_IDCODE: begin
                            st_nxt.dr_sh = {ID_VER, ID_PART, ID_MFR, 1'b1};
                        end
                        OP_DBG0, OP_DBG3: begin
                            st_nxt.dr_sh = 32'(st_r.chan);
                        end
                        OP_DBG2: begin
                            st_nxt.dr_sh = 32'({dbg_en, st_r.flow_en,
                                                st_r.step_en, st_r.chan_en,
                                                st_r.dirty, st_r.halted});
                        end
                        OP_RESET: begin
                            st_nxt.dr_sh = 32'(st_r.rst_bit);
                        end
                        default: begin
                            st_nxt.dr_sh = 32'h0;
                        end
                    endcase
                end
                TAP_SH_DR: begin
                    st_nxt.dr_sh = {st_r.tdi_p[1], st_r.dr_sh[31:1]};
                    if (op == OP_RESET) begin
                        st_nxt.rst_bit = st_r.tdi_p[1];
                    end
                end
                TAP_UPD_DR: begin
                    case (op)
                        OP_EXTEST, OP_SAMPLE: begin
                            st_nxt.bs_lat = upd[BS_W-1:0];
                        end
                        OP_DBG0: begin
                            st_nxt.dirty = 1'b0;
                        end
                        OP_DBG1: begin
                            if (st_r.halted) begin
                                st_nxt.instr = upd[15:0];
                                st_nxt.ivld = 1'b1;
                            end
                        end
                        OP_DBG2: begin
                            st_nxt.chan_en = upd[CTL_CHEN];
                            st_nxt.step_en = upd[CTL_STEP];
                            st_nxt.flow_en = upd[CTL_FLOW];
                            if (upd[CTL_RESUME]) begin
                                st_nxt.halted = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                TAP_CAP_IR: begin
                    st_nxt.ir_sh = IR_CAPTURE;
                end
                TAP_SH_IR: begin
                    st_nxt.ir_sh = {st_r.tdi_p[1], st_r.ir_sh[IR_W-1:1]};
                end
                TAP_UPD_IR: begin
                    st_nxt.ir = st_r.ir_sh;
                end
                default: begin
                end
            endcase
            st_nxt.state = tap_next(st_r.state, st_r.tms_p[1]);
        end else if (fall) begin
            // tdo changes on the falling edge, stable for the next rise
            if (st_r.state == TAP_SH_IR) begin
                st_nxt.tdo = st_r.ir_sh[0];
            end else begin
                st_nxt.tdo = st_r.dr_sh[0];
            end
            st_nxt.tdo_oe = (st_r.state == TAP_SH_IR)
                          || (st_r.state == TAP_SH_DR);
        end
        st_nxt.bs_drv = tap_en && (st_r.ir == OP_EXTEST);

        // ****************************************
        // break unit
        // ****************************************
        hit = bp_match(st_r.bp_mode, st_r.bp_en, st_r.bp, pc_vld, pc,
                       dacc_vld, daddr)
            | (st_r.step_en & pc_vld)
            | (st_r.flow_en & flow_chg);
        if (dbg_en && hit) begin
            st_nxt.halted = 1'b1;
        end

        // ****************************************
        // ahb-lite slave, one wait state per transfer
        // ****************************************
        st_nxt.hrdy = 1'b1;
        if (st_r.ap_vld) begin
            st_nxt.ap_vld = 1'b0;
            if (!st_r.ap_ok) begin
                st_nxt.hrdata = 32'h0;
            end else if (st_r.ap_wr) begin
                if (st_r.ap_addr == OFF_MCU) begin
                    st_nxt.jtd = hwdata[JTD_BIT];
                end else if (st_r.ap_addr == OFF_CHAN) begin
                    if (chan_acc) begin
                        st_nxt.chan = hwdata[7:0];
                        st_nxt.dirty = 1'b1;
                    end else begin
                        st_nxt.std_io = hwdata[7:0];
                    end
                end else if (st_r.ap_addr == OFF_BPCFG) begin
                    st_nxt.bp_mode = hwdata[2:0];
                    st_nxt.bp_en = hwdata[7:4];
                end else if (st_r.ap_addr == OFF_FUSE) begin
                    if (hwdata[FUSE_ERASE]) begin
                        st_nxt.erased = 1'b1;
                    end
                    if (hwdata[FUSE_PROG]) begin
                        st_nxt.fprog = ~locked | st_r.erased;
                    end
                end else begin
                    for (int i = 0; i < 4; i++) begin
                        if (st_r.ap_addr == bp_off(i)) begin
                            st_nxt.bp[i] = hwdata[15:0];
                        end
                    end
                end
            end else begin
                if (st_r.ap_addr == OFF_MCU) begin
                    rd = 32'({st_r.jtd, 7'h00});
                end else if (st_r.ap_addr == OFF_CHAN) begin
                    if (chan_acc) begin
                        rd = 32'({st_r.dirty, st_r.chan[6:0]});
                    end else begin
                        rd = 32'(st_r.std_io);
                    end
                end else if (st_r.ap_addr == OFF_STATUS) begin
                    rd = 32'({st_r.ir, st_r.state, st_r.erased, dbg_en,
                              tap_en, st_r.dirty, st_r.halted});
                end else if (st_r.ap_addr == OFF_BPCFG) begin
                    rd = 32'({st_r.bp_en, 1'b0, st_r.bp_mode});
                end else if (st_r.ap_addr == OFF_FUSE) begin
                    rd = 32'({st_r.erased, 1'b0});
                end else begin
                    for (int i = 0; i < 4; i++) begin
                        if (st_r.ap_addr == bp_off(i)) begin
                            rd = 32'(st_r.bp[i]);
                        end
                    end
                end
                st_nxt.hrdata = rd;
            end
        end else if (hsel && hready && htrans[1]) begin
            st_nxt.ap_vld = 1'b1;
            st_nxt.ap_wr = hwrite;
            st_nxt.ap_addr = haddr[7:0];
            st_nxt.ap_ok = (haddr[31:8] == 24'h0) && (hsize == HSIZE_WORD);
            st_nxt.hrdy = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.state <= TAP_TLR;
            st_r.ir <= OP_IDCODE;
            st_r.hrdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // the four tap pins and the ahb-lite slave are the paths in
    assign hreadyout    = st_r.hrdy;
    assign hrdata       = st_r.hrdata;
    assign hresp        = 1'b0;
    assign tdo          = st_r.tdo;
    assign tdo_oe       = st_r.tdo_oe;
    assign cpu_halt     = st_r.halted;
    assign instr        = st_r.instr;
    assign instr_vld    = st_r.ivld;
    assign sys_rst_req  = st_r.rst_bit;
    assign fuse_prog    = st_r.fprog;
    assign bs_pin_out   = st_r.bs_lat;
    assign bs_pin_drive = st_r.bs_drv;
endmodule
`default_nettype wire

// ---- testbench/jtd_tap_assertions.sv ----
// port checker for the jtag tap block
`timescale 1ns/1ps
`default_nettype none
module jtd_tap_assertions (
    input wire logic        hclk,      // clock
    input wire logic        hresetn,   // reset
    input wire logic        hsel,      // select
    input wire logic [1:0]  htrans,    // transfer
    input wire logic        hready,    // ready in
    input wire logic        hreadyout, // ready out
    input wire logic [31:0] hrdata,    // read data
    input wire logic        hresp,     // response
    input wire logic        tdo_oe,    // tdo drive
    input wire logic        test_port_enable_fuse, // fuse
    input wire logic        lock_bit_one, // lock
    input wire logic        cpu_halt,  // halted
    input wire logic        instr_vld, // injected
    input wire logic        fuse_prog, // fuse pulse
    input wire logic        bs_pin_drive // chain owns pins
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_okay_resp: assert property (hresp == 1'b0) else $error("response not okay");
    chk_one_wait: assert property (hsel && hready && htrans[1] && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("wait state not exactly one");
    chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
    chk_tap_off: assert property (!test_port_enable_fuse [*8] |-> !tdo_oe && !bs_pin_drive)
        else $error("tap active without fuse");
    chk_lock_noinj: assert property (lock_bit_one [*8] |-> !instr_vld) else $error("inject while locked");
    chk_inj_halted: assert property (instr_vld |-> cpu_halt) else $error("inject while running");
    chk_prog_pulse: assert property (fuse_prog |=> !fuse_prog) else $error("fuse pulse too long");
    chk_prog_cause: assert property (fuse_prog |-> $past(hsel && htrans[1], 2) || $past(hsel && htrans[1], 3))
        else $error("fuse pulse without write");
    cover property (instr_vld);
    cover property ($rose(cpu_halt));
    cover property (fuse_prog);
endmodule
bind jtd_tap jtd_tap_assertions u_chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hrdata, .hresp,
    .tdo_oe, .test_port_enable_fuse, .lock_bit_one, .cpu_halt, .instr_vld, .fuse_prog, .bs_pin_drive);
`default_nettype wire

// ---- testbench/jtd_jtag_host.sv ----
// jtag controller model driving the tap pins
`timescale 1ns/1ps
`default_nettype none
module jtd_jtag_host (
    output var logic tck, // test clock
    output var logic tms, // mode select
    output var logic tdi, // data in
    input wire logic tdo  // data out
);
    initial {tck, tms, tdi} = 3'b010;
    // tck edges stay off the hclk grid
    task automatic bit_io(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        #61.3 o = tdo;
        tck = 1'b1;
        #62.5 tck = 1'b0;
        #1.2;
    endtask
    // tdi toggles outside frames, no stale level
    task automatic move(input logic [4:0] s, input int n);
        logic o;
        for (int i = 0; i < n; i++) bit_io(s[i], ~tdi, o);
    endtask
    task automatic dr(input logic [31:0] din, input int n, output logic [31:0] dout);
        dout = '0;
        move(5'h01, 3);
        for (int i = 0; i < n; i++) bit_io(i == n - 1, din[i], dout[i]);
        move(5'h01, 2);
    endtask
    // ends in update-ir so a data scan can follow directly
    task automatic ir(input logic [3:0] op);
        logic [3:0] o;
        move(5'h03, 4);
        for (int i = 0; i < 4; i++) bit_io(i == 3, op[i], o[i]);
        move(5'h01, 1);
    endtask
endmodule
`default_nettype wire

// ---- testbench/jtd_tap_tb.sv ----
// self-checking bench for the jtag tap block
`timescale 1ns/1ps
`default_nettype none
module jtd_tap_tb;
    import jtd_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tck, tms, tdi, tdo, tdo_oe, pc_vld;
    logic cpu_halt, instr_vld, fuse_prog, bs_pin_drive;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] fz;
    logic [15:0] pc, instr;
    logic [7:0] bs_pin_in, bs_pin_out;
    int num_errors = 0, checks = 0, cyc = 0, nprog = 0, nvld = 0;
    jtd_tap u_jtd_tap (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .tck, .tms, .tdi, .tdo, .tdo_oe, .test_port_enable_fuse(fz[FZ_JTAG]),
        .debug_enable_fuse(fz[FZ_DBG]), .lock_bit_one(fz[FZ_LB1]), .lock_bit_two(fz[FZ_LB2]), .pc_vld, .pc,
        .dacc_vld(1'b0), .daddr(16'h0000), .flow_chg(1'b0), .cpu_halt, .instr, .instr_vld, .sys_rst_req(),
        .fuse_prog, .bs_pin_in, .bs_pin_out, .bs_pin_drive);
    jtd_jtag_host u_host (.tck, .tms, .tdi, .tdo(tdo_oe ? tdo : ~tdo));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(negedge hclk) begin
        cyc++;
        nprog += (fuse_prog === 1'b1);
        nvld += (instr_vld === 1'b1);
        if (cyc == 60000) begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single word transfer, read data taken at the ready edge
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        {hsel, htrans} <= 3'b110;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'b000;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(a, 1'b0, 32'h00000000, v);
        chk(v, e);
    endtask
    initial begin
        {hresetn, hsel, hwrite, pc_vld} = 4'h0;
        {haddr, hwdata, pc, htrans} = '0;
        hsize = HSIZE_WORD;
        fz = 4'h3;
        bs_pin_in = 8'hc3;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(OFF_STATUS, 32'h0000020c);
        rd(OFF_MCU, 32'h00000000);
        u_host.move(5'h00, 1);
        u_host.dr(32'h0, 32, v);
        chk(v, {ID_VER, ID_PART, ID_MFR, 1'b1});
        wr(OFF_CHAN, 32'h55);
        rd(OFF_CHAN, 32'h55);
        u_host.ir(OP_DBG2);
        u_host.dr(32'h2, 8, v);
        chk(v, 32'h20);
        wr(OFF_CHAN, 32'h2a);
        rd(OFF_CHAN, 32'haa);
        u_host.ir(OP_DBG0);
        u_host.dr(32'h0, 8, v);
        chk(v, 32'h2a);
        rd(OFF_CHAN, 32'h2a);
        wr(OFF_BPCFG, {24'h0, 4'h1, 1'b0, BP_4P});
        wr(OFF_BP0, 32'h0123);
        pc <= 16'h0123;
        pc_vld <= 1'b1;
        @(posedge hclk);
        pc_vld <= 1'b0;
        rd(OFF_STATUS, 32'h0000102d);
        u_host.ir(OP_DBG1);
        u_host.dr(32'hbeef, 16, v);
        chk(instr, 32'hbeef);
        chk(nvld, 1);
        u_host.ir(OP_DBG2);
        u_host.dr(32'h3, 8, v);
        chk(v, 32'h25);
        chk(cpu_halt, 1'b0);
        u_host.ir(OP_SAMPLE);
        u_host.dr(32'h5a, 8, v);
        chk(v, 32'hc3);
        chk(bs_pin_out, 32'h5a);
        chk(bs_pin_drive, 1'b0);
        u_host.ir(OP_EXTEST);
        u_host.move(5'h00, 1);
        chk(bs_pin_drive, 1'b1);
        u_host.move(5'h1f, 5);
        rd(OFF_STATUS, 32'h0000020c);
        wr(OFF_MCU, 32'h80);
        ahb(OFF_STATUS, 1'b0, 32'h0, v);
        chk(v[2], 1'b0);
        wr(OFF_MCU, 32'h00);
        fz[FZ_LB1] <= 1'b1;
        repeat (4) @(posedge hclk);
        wr(OFF_FUSE, 32'h2);
        chk(nprog, 0);
        wr(OFF_FUSE, 32'h1);
        wr(OFF_FUSE, 32'h2);
        chk(nprog, 1);
        fz[FZ_JTAG] <= 1'b0;
        repeat (12) @(posedge hclk);
        ahb(OFF_STATUS, 1'b0, 32'h0, v);
        chk(v[3:2], 2'b00);
        conclude();
    end
endmodule
`default_nettype wire
